//--- hw/rtcb_params.svh
`ifndef RTCB_PARAMS_SVH
`define RTCB_PARAMS_SVH
// ****************************************************************
// register offsets (byte addresses)
// ****************************************************************
`define RTCB_OFS_TIME       8'h00
`define RTCB_OFS_DATE       8'h04
`define RTCB_OFS_ALM_TIME   8'h08
`define RTCB_OFS_ALM_DATE   8'h0C
`define RTCB_OFS_CTRL       8'h10
`define RTCB_OFS_STATUS     8'h14
// ****************************************************************
// time word fields
// ****************************************************************
`define RTCB_HRT_MSB 30
`define RTCB_HRT_LSB 28
`define RTCB_HRU_MSB 27
`define RTCB_HRU_LSB 24
`define RTCB_MNT_MSB 22
`define RTCB_MNT_LSB 20
`define RTCB_MNU_MSB 19
`define RTCB_MNU_LSB 16
`define RTCB_SCT_MSB 15
`define RTCB_SCT_LSB 12
`define RTCB_SCU_MSB 11
`define RTCB_SCU_LSB 8
// ****************************************************************
// date word fields
// ****************************************************************
`define RTCB_MOT_MSB 20
`define RTCB_MOT_LSB 20
`define RTCB_MOU_MSB 19
`define RTCB_MOU_LSB 16
`define RTCB_DYT_MSB 13
`define RTCB_DYT_LSB 12
`define RTCB_DYU_MSB 11
`define RTCB_DYU_LSB 8
`define RTCB_WDY_MSB 2
`define RTCB_WDY_LSB 0
// ****************************************************************
// control and status bits, masks, reset values
// ****************************************************************
`define RTCB_CTRL_ON_BIT    15
`define RTCB_CTRL_LOCK_BIT  11
`define RTCB_STAT_SYNC_BIT  2
`define RTCB_STAT_HALF_BIT  0
`define RTCB_TIME_MASK      32'h7F7FFF00
`define RTCB_DATE_MASK      32'h001F3F07
`define RTCB_CTRL_MASK      32'h00008800
`define RTCB_RST_WORD       32'h00000000
// ****************************************************************
// timing
// ****************************************************************
`define RTCB_CLK_NS         25
`define RTCB_SEC_NS         1000000000
`define RTCB_SYNC_NS        1000
`endif

//--- hw/rtcb_pkg.sv
// ****************************************************************
// shared types
// ****************************************************************
package rtcb_pkg;
  // write channel progress
  typedef enum logic [1:0] {
    RTCB_WR_IDLE = 2'b00,
    RTCB_WR_ADDR = 2'b01,
    RTCB_WR_DATA = 2'b10,
    RTCB_WR_RESP = 2'b11
  } rtcb_wr_state_type;
  // register select
  typedef enum logic [2:0] {
    RTCB_SEL_TIME   = 3'b000,
    RTCB_SEL_DATE   = 3'b001,
    RTCB_SEL_ATIME  = 3'b010,
    RTCB_SEL_ADATE  = 3'b011,
    RTCB_SEL_CTRL   = 3'b100,
    RTCB_SEL_STATUS = 3'b101,
    RTCB_SEL_NONE   = 3'b111
  } rtcb_sel_type;
endpackage

//--- hw/rtcb_cal_if.sv
`timescale 1ns/100ps
`default_nettype none
// ****************************************************************
// link between register front end and calendar counters
// ****************************************************************
interface rtcb_cal_if;
  logic        tick;       // one-cycle seconds strobe
  logic        load_time;  // software load of time word
  logic        load_date;  // software load of date word
  logic [31:0] wdata;      // merged write word
  logic [31:0] time_word;  // running time
  logic [31:0] date_word;  // running date
  modport ctl (output tick, output load_time, output load_date, output wdata,
               input time_word, input date_word);
  modport cal (input tick, input load_time, input load_date, input wdata,
               output time_word, output date_word);
endinterface
`default_nettype wire

//--- hw/rtcb_calendar.sv
`timescale 1ns/100ps
`default_nettype none
`include "rtcb_params.svh"
// ****************************************************************
// bcd time and date counters
// ****************************************************************
module rtcb_calendar import rtcb_pkg::*; (
  input wire logic clk,
  input wire logic rst_n,
  rtcb_cal_if.cal  cal
);
  logic [31:0] time_reg, time_next;  // running time
  logic [31:0] date_reg, date_next;  // running date

  // step a bcd pair, wrap at last; bit 8 is the carry
  function automatic logic [8:0] bcd_step(input logic [7:0] v, input logic [7:0] last,
                                          input logic [7:0] first);
    logic [8:0] r;
    r = 9'h000;
    if (v >= last) r = {1'b1, first};
    else if (v[3:0] >= 4'h9) r = {1'b0, v[7:4] + 4'h1, 4'h0};
    else r = {1'b0, v + 8'h01};
    return r;
  endfunction

  // last day of a bcd month, no leap years
  function automatic logic [7:0] last_day(input logic [7:0] mon);
    case (mon)
      8'h02: last_day = 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: last_day = 8'h30;
      default: last_day = 8'h31;
    endcase
  endfunction

  // next values of the counters
  always_comb begin
    logic [8:0] s, m, h, d, mo;
    logic       day_carry;
    s = 9'h000;
    m = 9'h000;
    h = 9'h000;
    d = 9'h000;
    mo = 9'h000;
    day_carry = 1'b0;
    time_next = time_reg;
    date_next = date_reg;
    s = bcd_step(time_reg[`RTCB_SCT_MSB:`RTCB_SCU_LSB], 8'h59, 8'h00);
    m = bcd_step({1'b0, time_reg[`RTCB_MNT_MSB:`RTCB_MNU_LSB]}, 8'h59, 8'h00);
    h = bcd_step({1'b0, time_reg[`RTCB_HRT_MSB:`RTCB_HRU_LSB]}, 8'h23, 8'h00);
    if (cal.load_time) begin  // software wins over the tick
      time_next = cal.wdata & `RTCB_TIME_MASK;  // see RL7
    end else if (cal.tick) begin
      time_next[`RTCB_SCT_MSB:`RTCB_SCU_LSB] = s[7:0];  // see RL5 see RL6 see RL19
      if (s[8]) begin
        time_next[`RTCB_MNT_MSB:`RTCB_MNU_LSB] = m[6:0];  // see RL3 see RL4
        if (m[8]) begin
          time_next[`RTCB_HRT_MSB:`RTCB_HRU_LSB] = h[6:0];  // see RL1 see RL2
          day_carry = h[8];
        end
      end
    end
    d = bcd_step({2'b00, date_reg[`RTCB_DYT_MSB:`RTCB_DYU_LSB]},
                 last_day({3'b000, date_reg[`RTCB_MOT_MSB:`RTCB_MOU_LSB]}), 8'h01);
    mo = bcd_step({3'b000, date_reg[`RTCB_MOT_MSB:`RTCB_MOU_LSB]}, 8'h12, 8'h01);
    if (cal.load_date) begin
      date_next = cal.wdata & `RTCB_DATE_MASK;  // see RL13
    end else if (day_carry) begin
      date_next[`RTCB_DYT_MSB:`RTCB_DYU_LSB] = d[5:0];  // see RL10 see RL11
      date_next[`RTCB_WDY_MSB:`RTCB_WDY_LSB] =
        (date_reg[`RTCB_WDY_MSB:`RTCB_WDY_LSB] >= 3'h6) ? 3'h0
        : date_reg[`RTCB_WDY_MSB:`RTCB_WDY_LSB] + 3'h1;  // see RL12 see RL20
      if (d[8]) date_next[`RTCB_MOT_MSB:`RTCB_MOU_LSB] = mo[4:0];  // see RL8 see RL9
    end
  end

  // counter registers, cleared by reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      time_reg <= `RTCB_RST_WORD;  // see RL15
      date_reg <= `RTCB_RST_WORD;
    end else begin
      time_reg <= time_next;
      date_reg <= date_next;
    end
  end

  assign cal.time_word = time_reg;
  assign cal.date_word = date_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_last_second;
    cal.tick && !cal.load_time && time_reg[15:8] == 8'h59;
  endsequence
  sequence s_midnight;
    s_last_second ##0 time_reg[22:16] == 7'h59 ##0 time_reg[30:24] == 7'h23;
  endsequence
  AST_SEC_WRAP: assert property (s_last_second |=> time_reg[15:8] == 8'h00)  // see RL5
    else $error("seconds did not wrap to zero");
  AST_HOUR_WRAP: assert property (s_midnight |=> time_reg[30:16] == 15'h0000)  // see RL1
    else $error("hours did not wrap at midnight");
  AST_WEEKDAY: assert property (s_midnight ##0 !cal.load_date |=>  // see RL20
      date_reg[2:0] == (($past(date_reg[2:0]) >= 3'h6) ? 3'h0 : $past(date_reg[2:0]) + 3'h1))
    else $error("weekday did not step with the day");
  AST_TIME_RSV: assert property (1'b1 |=> (time_reg & ~`RTCB_TIME_MASK) == 32'h0)  // see RL7
    else $error("time word reserved bits set");
endmodule
`default_nettype wire

//--- hw/rtcb_regs.sv
`timescale 1ns/100ps
`default_nettype none
`include "rtcb_params.svh"
// Function
// RL1 - hour tens digit, bits 30:28, 0 to 2
// RL2 - hour units digit, bits 27:24, 0 to 9
// RL3 - minute tens digit, bits 22:20, 0 to 5
// RL4 - minute units digit, bits 19:16, 0 to 9
// RL5 - second tens digit, bits 15:12, 0 to 5
// RL6 - second units digit, bits 11:8, 0 to 9
// RL7 - time unused bits ignore writes, read zero
// RL8 - month tens digit at date bit 20
// RL9 - month units digit, bits 19:16, 0 to 9
// RL10 - day tens digit, bits 13:12, 0 to 3
// RL11 - day units digit, bits 11:8, 0 to 9
// RL12 - weekday in bits 2:0, 0 to 6
// RL13 - date unused bits ignore writes, read zero
// RL14 - alarm words share time and date layout
// RL15 - all writable fields zero after reset
// RL16 - read time only while sync flag clear
// RL17 - software leaves alarm words alone while pending
// RL18 - write lock blocks time and date writes
// RL19 - seconds tick carries through the whole calendar
// RL20 - weekday steps with day, 6 wraps to 0
module rtcb_regs import rtcb_pkg::*; #(
  parameter int unsigned SEC_CYCLES  = `RTCB_SEC_NS / `RTCB_CLK_NS,   // clocks per second
  parameter int unsigned SYNC_CYCLES = `RTCB_SYNC_NS / `RTCB_CLK_NS,  // sync window
  parameter int unsigned ADDR_W      = 8                               // bus address width
) (
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic [2:0]        AWPROT,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic [2:0]        ARPROT,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY
);
  localparam int CW = $clog2(SEC_CYCLES + 1);  // prescaler width

  // ****************************************************************
  // state
  // ****************************************************************
  rtcb_cal_if cal_if ();                                      // calendar link
  rtcb_wr_state_type wr_state_reg, wr_state_next;            // write channel
  logic [ADDR_W-1:0] awaddr_reg, awaddr_next;                // held address
  logic [31:0]       wdata_reg, wdata_next;                  // held data
  logic [3:0]        wstrb_reg, wstrb_next;                  // held strobes
  logic [1:0]        bresp_reg, bresp_next;                  // write answer
  logic              rvalid_reg, rvalid_next;                // read answer valid
  logic [31:0]       rdata_reg, rdata_next;                  // read data
  logic [1:0]        rresp_reg, rresp_next;                  // read answer code
  logic [31:0]       atime_reg, atime_next;                  // alarm time
  logic [31:0]       adate_reg, adate_next;                  // alarm date
  logic [31:0]       ctrl_reg, ctrl_next;                    // control one
  logic [CW-1:0]     cnt_reg, cnt_next;                      // seconds prescaler
  logic              do_write;                               // write commits now
  logic [ADDR_W-1:0] w_addr;                                 // address of commit
  logic [31:0]       w_data;                                 // data of commit
  logic [3:0]        w_strb;                                 // strobes of commit
  logic [31:0]       byte_mask;                              // strobes as bits
  rtcb_sel_type      w_sel;                                  // decoded write target
  logic              sync_flag;                              // time may change soon
  logic              half_flag;                              // second half of second
  logic              locked;                                 // timekeeping write lock

  // address decode, shared by read and write
  function automatic rtcb_sel_type decode(input logic [ADDR_W-1:0] a);
    case (a)
      ADDR_W'(`RTCB_OFS_TIME):     decode = RTCB_SEL_TIME;
      ADDR_W'(`RTCB_OFS_DATE):     decode = RTCB_SEL_DATE;
      ADDR_W'(`RTCB_OFS_ALM_TIME): decode = RTCB_SEL_ATIME;
      ADDR_W'(`RTCB_OFS_ALM_DATE): decode = RTCB_SEL_ADATE;
      ADDR_W'(`RTCB_OFS_CTRL):     decode = RTCB_SEL_CTRL;
      ADDR_W'(`RTCB_OFS_STATUS):   decode = RTCB_SEL_STATUS;
      default:                     decode = RTCB_SEL_NONE;
    endcase
  endfunction

  // ****************************************************************
  // calendar counters
  // ****************************************************************
  rtcb_calendar u_cal (
    .clk (CLK),
    .rst_n (RST_N),
    .cal (cal_if.cal)
  );

  // ****************************************************************
  // seconds prescaler and status flags
  // ****************************************************************
  assign locked    = ctrl_reg[`RTCB_CTRL_LOCK_BIT];
  assign sync_flag = ctrl_reg[`RTCB_CTRL_ON_BIT] &&
                     (cnt_reg >= CW'(SEC_CYCLES - SYNC_CYCLES));  // see RL16
  assign half_flag = cnt_reg >= CW'(SEC_CYCLES / 2);

  // prescaler counts only while the clock is switched on
  always_comb begin
    cnt_next = cnt_reg;
    cal_if.tick = 1'b0;
    if (!ctrl_reg[`RTCB_CTRL_ON_BIT]) begin
      cnt_next = '0;  // held at start of second
    end else if (cnt_reg == CW'(SEC_CYCLES - 1)) begin
      cnt_next = '0;
      cal_if.tick = 1'b1;  // see RL19
    end else begin
      cnt_next = cnt_reg + CW'(1);
    end
  end

  // ****************************************************************
  // write channel
  // ****************************************************************
  assign AWREADY = (wr_state_reg == RTCB_WR_IDLE) || (wr_state_reg == RTCB_WR_DATA);
  assign WREADY  = (wr_state_reg == RTCB_WR_IDLE) || (wr_state_reg == RTCB_WR_ADDR);
  assign BVALID  = wr_state_reg == RTCB_WR_RESP;
  assign BRESP   = bresp_reg;

  // pick live or held halves of the write
  always_comb begin
    w_addr = (AWVALID && AWREADY) ? AWADDR : awaddr_reg;
    w_data = (WVALID && WREADY) ? WDATA : wdata_reg;
    w_strb = (WVALID && WREADY) ? WSTRB : wstrb_reg;
    w_sel  = decode(w_addr);
    for (int i = 0; i < 4; i++) begin
      byte_mask[i*8 +: 8] = {8{w_strb[i]}};
    end
  end

  // channel sequencing, either half may come first
  always_comb begin
    wr_state_next = wr_state_reg;
    awaddr_next   = awaddr_reg;
    wdata_next    = wdata_reg;
    wstrb_next    = wstrb_reg;
    bresp_next    = bresp_reg;
    do_write      = 1'b0;
    if (AWVALID && AWREADY) awaddr_next = AWADDR;
    if (WVALID && WREADY) begin
      wdata_next = WDATA;
      wstrb_next = WSTRB;
    end
    case (wr_state_reg)
      RTCB_WR_IDLE: begin
        if (AWVALID && WVALID) do_write = 1'b1;
        else if (AWVALID) wr_state_next = RTCB_WR_ADDR;
        else if (WVALID) wr_state_next = RTCB_WR_DATA;
      end
      RTCB_WR_ADDR: begin
        if (WVALID) do_write = 1'b1;
      end
      RTCB_WR_DATA: begin
        if (AWVALID) do_write = 1'b1;
      end
      RTCB_WR_RESP: begin
        if (BREADY) wr_state_next = RTCB_WR_IDLE;
      end
      default: wr_state_next = RTCB_WR_IDLE;
    endcase
    if (do_write) begin
      wr_state_next = RTCB_WR_RESP;
      bresp_next = (w_sel == RTCB_SEL_NONE) ? 2'b10 : 2'b00;  // unmapped gives SLVERR
    end
  end

  // register targets of a committed write
  always_comb begin
    atime_next = atime_reg;
    adate_next = adate_reg;
    ctrl_next  = ctrl_reg;
    cal_if.load_time = 1'b0;
    cal_if.load_date = 1'b0;
    cal_if.wdata = 32'h00000000;
    if (do_write) begin
      case (w_sel)
        RTCB_SEL_TIME: begin
          cal_if.load_time = !locked;  // see RL18
          cal_if.wdata = (cal_if.time_word & ~byte_mask) | (w_data & byte_mask);
        end
        RTCB_SEL_DATE: begin
          cal_if.load_date = !locked;  // see RL18
          cal_if.wdata = (cal_if.date_word & ~byte_mask) | (w_data & byte_mask);
        end
        RTCB_SEL_ATIME:
          atime_next = ((atime_reg & ~byte_mask) | (w_data & byte_mask))
                       & `RTCB_TIME_MASK;  // see RL14
        RTCB_SEL_ADATE:
          adate_next = ((adate_reg & ~byte_mask) | (w_data & byte_mask))
                       & `RTCB_DATE_MASK;  // see RL14
        RTCB_SEL_CTRL:
          ctrl_next = ((ctrl_reg & ~byte_mask) | (w_data & byte_mask)) & `RTCB_CTRL_MASK;
        default: ctrl_next = ctrl_reg;  // status and unmapped hold
      endcase
    end
  end

  // ****************************************************************
  // read channel
  // ****************************************************************
  assign ARREADY = !rvalid_reg;
  assign RVALID  = rvalid_reg;
  assign RDATA   = rdata_reg;
  assign RRESP   = rresp_reg;

  // one read in flight, answered the cycle after the address
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (rvalid_reg && RREADY) rvalid_next = 1'b0;
    if (ARVALID && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = 2'b00;
      case (decode(ARADDR))
        RTCB_SEL_TIME:   rdata_next = cal_if.time_word & `RTCB_TIME_MASK;  // see RL7
        RTCB_SEL_DATE:   rdata_next = cal_if.date_word & `RTCB_DATE_MASK;  // see RL13
        RTCB_SEL_ATIME:  rdata_next = atime_reg;
        RTCB_SEL_ADATE:  rdata_next = adate_reg;
        RTCB_SEL_CTRL:   rdata_next = ctrl_reg;
        RTCB_SEL_STATUS: begin
          rdata_next = 32'h00000000;
          rdata_next[`RTCB_STAT_SYNC_BIT] = sync_flag;
          rdata_next[`RTCB_STAT_HALF_BIT] = half_flag;
        end
        default: begin
          rdata_next = 32'h00000000;
          rresp_next = 2'b10;  // unmapped
        end
      endcase
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wr_state_reg <= RTCB_WR_IDLE;
      awaddr_reg   <= '0;
      wdata_reg    <= 32'h00000000;
      wstrb_reg    <= 4'h0;
      bresp_reg    <= 2'b00;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= 32'h00000000;
      rresp_reg    <= 2'b00;
      atime_reg    <= `RTCB_RST_WORD;  // see RL15
      adate_reg    <= `RTCB_RST_WORD;
      ctrl_reg     <= `RTCB_RST_WORD;
      cnt_reg      <= '0;
    end else begin
      wr_state_reg <= wr_state_next;
      awaddr_reg   <= awaddr_next;
      wdata_reg    <= wdata_next;
      wstrb_reg    <= wstrb_next;
      bresp_reg    <= bresp_next;
      rvalid_reg   <= rvalid_next;
      rdata_reg    <= rdata_next;
      rresp_reg    <= rresp_next;
      atime_reg    <= atime_next;
      adate_reg    <= adate_next;
      ctrl_reg     <= ctrl_next;
      cnt_reg      <= cnt_next;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_locked_time_write;
    do_write && w_sel == RTCB_SEL_TIME && locked && !cal_if.tick;
  endsequence
  AST_LOCK_HOLD: assert property (s_locked_time_write |=>  // see RL18
      cal_if.time_word == $past(cal_if.time_word))
    else $error("locked time word changed by a write");
  AST_UNLOCK_LOAD: assert property (do_write && w_sel == RTCB_SEL_DATE && !locked  // see RL18
      && w_strb == 4'hF |=> cal_if.date_word == ($past(w_data) & `RTCB_DATE_MASK))
    else $error("unlocked date write not stored");
  AST_ALARM_LAYOUT: assert property (do_write && w_sel == RTCB_SEL_ATIME  // see RL14
      && w_strb == 4'hF |=> atime_reg == ($past(w_data) & `RTCB_TIME_MASK))
    else $error("alarm time not stored with time layout");
  AST_DATE_READ_RSV: assert property (ARVALID && ARREADY  // see RL13
      && decode(ARADDR) == RTCB_SEL_DATE
      |=> RVALID && (RDATA & ~`RTCB_DATE_MASK) == 32'h0)
    else $error("date read shows reserved bits");
  AST_TICK_SYNC: assert property (cal_if.tick |-> sync_flag ##1 !sync_flag)  // see RL16
    else $error("tick outside sync window");
  AST_RESET_ZERO: assert property (@(posedge CLK) disable iff (1'b0)  // see RL15
      !RST_N |=> cal_if.time_word == 32'h0 && cal_if.date_word == 32'h0
      && atime_reg == 32'h0 && adate_reg == 32'h0)
    else $error("fields not zero after reset");
endmodule
`default_nettype wire

//--- verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "rtcb_params.svh"
module tb_top import rtcb_pkg::*;;
  // ****************************************************************
  // clock, reset, bus signals
  // ****************************************************************
  logic        clk = 1'b0;       // 40 MHz
  logic        rst_n = 1'b0;     // sync reset
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0]  wstrb = 4'h0;
  logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  int          err_total = 0, tests_run = 0, cyc = 0;
  logic [31:0] d;                // read data
  logic [1:0]  r;                // response
  always #12.5 clk = ~clk;
  rtcb_regs #(.SEC_CYCLES(100), .SYNC_CYCLES(10), .ADDR_W(8)) rtcb_regs_i (
    .CLK(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWPROT(3'h0), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARPROT(3'h0),
    .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
    .RVALID(rvalid), .RREADY(rready));
  // ****************************************************************
  // bus tasks; ready and answers taken at the rising edge that completes them
  // ****************************************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s);
    logic ah;
    logic wh;
    ah = 1'b1;
    wh = 1'b1;
    @(posedge clk);
    awaddr  <= a;
    wdata   <= v;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    while (ah || wh) begin
      @(posedge clk);
      if (ah && awready === 1'b1) begin
        ah = 1'b0;
        awvalid <= 1'b0;
      end
      if (wh && wready === 1'b1) begin
        wh = 1'b0;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // ****************************************************************
  // compares and verdict
  // ****************************************************************
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: data %h, wanted %h", $time, g, e);
    end
  endtask
  task automatic chkr(input logic [1:0] e, input logic [1:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("unexpected at %0t: resp %b, wanted %b", $time, g, e);
    end
  endtask
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      rd(8'(4 * i));
      chk(32'h0, d);
      chkr(2'b00, r);
    end
    rd(8'h18);
    chkr(2'b10, r);  // unmapped place refused
    chk(32'h0, d);
    $display("test reset done");
  endtask
  task automatic t_fields;
    logic [31:0] m [4] = '{32'h7F7FFF00, 32'h001F3F07, 32'h7F7FFF00, 32'h001F3F07};
    for (int i = 0; i < 4; i++) begin
      wr(8'(4 * i), 32'hFFFFFFFF, 4'hF);
      chkr(2'b00, r);
      rd(8'(4 * i));
      chk(m[i], d);
    end
    wr(`RTCB_OFS_ALM_TIME, 32'h00001200, 4'h2);
    rd(`RTCB_OFS_ALM_TIME);
    chk(32'h7F7F1200, d);
    wr(8'h18, 32'h1, 4'hF);
    chkr(2'b10, r);
    $display("test fields done");
  endtask
  task automatic t_lock;
    wr(`RTCB_OFS_CTRL, 32'h00000800, 4'hF);
    wr(`RTCB_OFS_TIME, 32'h12345600, 4'hF);
    rd(`RTCB_OFS_TIME);
    chk(32'h7F7FFF00, d);
    rd(`RTCB_OFS_STATUS);
    chk(32'h0, d);
    wr(`RTCB_OFS_ALM_DATE, 32'h00010203, 4'hF);
    rd(`RTCB_OFS_ALM_DATE);
    chk(32'h00010203, d);
    wr(`RTCB_OFS_CTRL, 32'h0, 4'hF);
    $display("test lock done");
  endtask
  task automatic t_roll;
    wr(`RTCB_OFS_TIME, 32'h23595900, 4'hF);
    wr(`RTCB_OFS_DATE, 32'h00123106, 4'hF);
    wr(`RTCB_OFS_CTRL, 32'h00008000, 4'hF);
    repeat (92) @(posedge clk);
    rd(`RTCB_OFS_STATUS);
    chk(32'h5, d);
    repeat (30) @(posedge clk);
    rd(`RTCB_OFS_TIME);
    chk(32'h0, d);
    rd(`RTCB_OFS_DATE);
    chk(32'h00010100, d);
    $display("test rollover done");
  endtask
  // ****************************************************************
  // main sequence and hang guard
  // ****************************************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_total++;
      $display("unexpected at %0t: run timed out", $time);
      close_out();
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_fields();
    t_lock();
    t_roll();
    close_out();
  end
endmodule
`default_nettype wire
